// >>> dtilm_pkg.sv
/*
 dual timer package: modes, targets, interrupt bit positions, widths, reset values.
 assumes every user of the block shares one clock and imports this whole package.
*/
// Behaviour
// - clear mask drops the selected pending sources
// - only enabled pending sources drive irq_out
// - seven sources: three per half plus rtc
// - status reads raw or masked by select
// - load write reaches running counter at once
// - load readback returns last programmed value
// - edge count equal to match raises match
// - pwm duty set by match value
// - prescaler accepts values 0 through 255
// - prescaler works only in paired mode
// - clearing rtc enable halts rtc counter
// - rtc enable set ignored outside rtc mode
// - value read returns live half count; half a returns the joined 32-bit count when joined
// - writes target half a, b or both
// - joined and paired modes all supported
// - half timeout raised when counter hits zero in one-shot or periodic mode
// - stall option freezes counting in debug
package dtilm_pkg;
	typedef enum logic [1:0] {
		DTILM_J32_ONESHOT = 2'h0,
		DTILM_J32_PERIODIC = 2'h1,
		DTILM_J32_RTC = 2'h2,
		DTILM_PAIR16 = 2'h3
	} dtilm_join_type;
	typedef enum logic [2:0] {
		DTILM_H_ONESHOT = 3'h0,
		DTILM_H_PERIODIC = 3'h1,
		DTILM_H_CAP_COUNT = 3'h2,
		DTILM_H_CAP_TIME = 3'h3,
		DTILM_H_PWM = 3'h4
	} dtilm_half_mode_type;
	typedef enum logic [1:0] {
		DTILM_KIND_LOAD = 2'h0,
		DTILM_KIND_MATCH = 2'h1,
		DTILM_KIND_PRESCALE = 2'h2,
		DTILM_KIND_VALUE = 2'h3
	} dtilm_kind_type;
	// wr_target bit positions; both bits set writes both halves
	localparam int DTILM_TGT_A = 0;
	localparam int DTILM_TGT_B = 1;
	localparam int DTILM_HALF_W = 16;
	localparam int DTILM_FULL_W = 32;
	localparam int DTILM_PRESCALE_W = 8;
	localparam int DTILM_NUM_IRQ = 7;
	// interrupt bit positions
	localparam int DTILM_IRQ_A_TIMEOUT = 0;
	localparam int DTILM_IRQ_A_CMATCH = 1;
	localparam int DTILM_IRQ_A_CEVENT = 2;
	localparam int DTILM_IRQ_RTC = 3;
	localparam int DTILM_IRQ_B_TIMEOUT = 4;
	localparam int DTILM_IRQ_B_CMATCH = 5;
	localparam int DTILM_IRQ_B_CEVENT = 6;
	// reset values
	localparam logic [31:0] DTILM_LOAD_RESET = 32'h0000_0000;
	localparam logic [31:0] DTILM_MATCH_RESET = 32'h0000_0000;
	localparam logic [7:0] DTILM_PRESCALE_RESET = 8'h00;
	localparam logic [6:0] DTILM_RAW_RESET = 7'h00;
endpackage : dtilm_pkg

// >>> dtilm_half_if.sv
/*
 carrier between the timer top and one 16-bit half.
 assumes both ends run on the top's clock and synchronised reset.
*/
interface dtilm_half_if;
	import dtilm_pkg::*;
	logic run;
	dtilm_half_mode_type mode;
	logic [DTILM_HALF_W-1:0] load;
	logic [DTILM_HALF_W-1:0] match;
	logic [DTILM_PRESCALE_W-1:0] prescale;
	logic load_strobe;
	logic stall;
	logic cap_edge;
	logic [DTILM_HALF_W-1:0] count;
	logic timeout;
	logic cap_match;
	logic cap_event;
	logic pwm;
	modport ctrl (output run, mode, load, match, prescale, load_strobe, stall, cap_edge,
		input count, timeout, cap_match, cap_event, pwm);
	modport half (input run, mode, load, match, prescale, load_strobe, stall, cap_edge,
		output count, timeout, cap_match, cap_event, pwm);
endinterface : dtilm_half_if

// >>> dtilm_half.sv
/*
 one 16-bit timer half: one-shot, periodic, edge count, edge time, pwm.
 assumes cap_edge is already synchronised and a single-cycle pulse.
*/
module dtilm_half
	import dtilm_pkg::*;
#(
	parameter int CNT_W = DTILM_HALF_W,
	parameter int PRE_W = DTILM_PRESCALE_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control and results
	dtilm_half_if.half hif
);
	generate
		if (CNT_W != DTILM_HALF_W || PRE_W != DTILM_PRESCALE_W) begin : g_bad_width
			$error("dtilm_half widths must match the carrier");
		end
	endgenerate

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [PRE_W-1:0] pre;
		logic timeout;
		logic cap_match;
		logic cap_event;
		logic pwm;
	} dtilm_half_state_type;

	localparam dtilm_half_state_type HALF_RESET = '{default: '0};

	dtilm_half_state_type q;
	dtilm_half_state_type d;
	logic tick;
	logic [CNT_W-1:0] nxt;

	always_comb begin
		d = q;
		d.timeout = 1'b0;
		d.cap_match = 1'b0;
		d.cap_event = 1'b0;
		tick = 1'b0;
		nxt = (q.cnt == '0) ? hif.load : q.cnt - 1'b1;
		if (!hif.run) begin
			d.pre = '0;
		end else if (!hif.stall) begin
			// prescale 0 ticks every clock; 255 every 256th
			if (q.pre >= hif.prescale) begin
				d.pre = '0;
				tick = 1'b1;
			end else begin
				d.pre = q.pre + 1'b1;
			end
			case (hif.mode)
				DTILM_H_ONESHOT: begin
					// one-shot rests at zero until reloaded
					if (tick && q.cnt != '0) begin
						d.cnt = q.cnt - 1'b1;
						d.timeout = (q.cnt == 1);
					end
				end
				DTILM_H_PERIODIC, DTILM_H_PWM, DTILM_H_CAP_TIME: begin
					if (tick) begin
						d.cnt = nxt;
						d.timeout = (hif.mode == DTILM_H_PERIODIC) && (nxt == '0);
					end
					d.cap_event = (hif.mode == DTILM_H_CAP_TIME) && hif.cap_edge;
				end
				DTILM_H_CAP_COUNT: begin
					// edges are counted directly, the prescaler does not divide them
					if (hif.cap_edge) begin
						d.cnt = nxt;
						d.cap_event = 1'b1;
						d.cap_match = (nxt == hif.match);
					end
				end
				default: ;
			endcase
		end
		if (hif.load_strobe) begin
			d.cnt = hif.load;
			d.pre = '0;
		end
		d.pwm = hif.run && (hif.mode == DTILM_H_PWM) && (d.cnt > hif.match);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= HALF_RESET;
		end else begin
			q <= d;
		end
	end

	assign hif.count = q.cnt;
	assign hif.timeout = q.timeout;
	assign hif.cap_match = q.cap_match;
	assign hif.cap_event = q.cap_event;
	assign hif.pwm = q.pwm;

	chk_load_immediate: assert property (@(posedge clk) disable iff (!rst_n)
		hif.load_strobe |=> hif.count == $past(hif.load))
		else $error("load strobe did not reach counter");
	chk_pwm_duty: assert property (@(posedge clk) disable iff (!rst_n)
		(hif.mode == DTILM_H_PWM) && hif.run && $stable(hif.match) && $stable(hif.run)
		&& $stable(hif.mode)
		|-> hif.pwm == (hif.count > hif.match))
		else $error("pwm level disagrees with match");
	chk_stall_hold: assert property (@(posedge clk) disable iff (!rst_n)
		hif.run && hif.stall && !hif.load_strobe |=> $stable(hif.count))
		else $error("half counted while stalled");
	chk_timeout_zero: assert property (@(posedge clk) disable iff (!rst_n)
		hif.timeout |-> hif.count == '0)
		else $error("timeout without zero count");
	chk_cap_match: assert property (@(posedge clk) disable iff (!rst_n)
		hif.cap_match |-> hif.count == $past(hif.match) && hif.cap_event)
		else $error("capture match without equal count");
	cov_pwm_rise: cover property (@(posedge clk) disable iff (!rst_n) $rose(hif.pwm));
endmodule : dtilm_half

// >>> dtilm_timer.sv
/*
 dual timer top: joined 32-bit counter and rtc, two 16-bit halves, interrupt status.
 assumes control ports are driven from logic on ref_clk; ccp pins are asynchronous.
*/
module dtilm_timer
	import dtilm_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// mode configuration
	input wire dtilm_join_type join_mode,
	input wire dtilm_half_mode_type half_a_mode,
	input wire dtilm_half_mode_type half_b_mode,
	input wire logic timer_a_enable,
	input wire logic timer_b_enable,
	input wire logic debug_halt_option_a,
	input wire logic debug_halt_option_b,
	input wire logic debug_mode,
	// rtc count enable
	input wire logic rtc_enable_set,
	input wire logic rtc_enable_clear,
	// value writes
	input wire logic wr_valid,
	input wire logic [1:0] wr_target,
	input wire dtilm_kind_type wr_kind,
	input wire logic [31:0] wr_data,
	// value reads
	input wire logic rd_valid,
	input wire logic rd_half_b,
	input wire dtilm_kind_type rd_kind,
	output logic [31:0] rd_data,
	output logic rd_done,
	// interrupts
	input wire logic [6:0] irq_enable,
	input wire logic irq_clear_valid,
	input wire logic [6:0] irq_clear_mask,
	input wire logic masked_status_select,
	output logic [6:0] irq_status,
	output logic irq_out,
	// capture and pwm pins
	input wire logic ccp_a_in,
	output logic ccp_a_out,
	output logic ccp_a_oe,
	input wire logic ccp_b_in,
	output logic ccp_b_out,
	output logic ccp_b_oe
);
	typedef struct packed {
		logic [2:0] sync_a;
		logic [2:0] sync_b;
		logic [31:0] load_a;
		logic [15:0] load_b;
		logic [31:0] match_a;
		logic [15:0] match_b;
		logic [7:0] pre_a;
		logic [7:0] pre_b;
		logic ld_a;
		logic ld_b;
		logic [31:0] cnt32;
		logic rtc_run;
		logic t32_timeout;
		logic rtc_match;
		logic [6:0] raw;
		logic [6:0] status;
		logic irq;
		logic [31:0] rd_data;
		logic rd_done;
	} dtilm_state_type;

	localparam dtilm_state_type TOP_RESET = '{default: '0,
		load_a: DTILM_LOAD_RESET, load_b: DTILM_LOAD_RESET[15:0],
		match_a: DTILM_MATCH_RESET, match_b: DTILM_MATCH_RESET[15:0],
		pre_a: DTILM_PRESCALE_RESET, pre_b: DTILM_PRESCALE_RESET, raw: DTILM_RAW_RESET};

	function automatic logic [31:0] ext16(input logic [15:0] v);
		ext16 = {16'h0000, v};
	endfunction : ext16

	logic [1:0] rst_sync_q;
	logic rst_n;
	logic pair;
	logic stall_a;
	logic [6:0] ev;
	dtilm_state_type q;
	dtilm_state_type d;
	dtilm_half_if hif_a ();
	dtilm_half_if hif_b ();

	// reset asserts at once, releases two edges later
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	assign pair = (join_mode == DTILM_PAIR16);
	assign stall_a = debug_halt_option_a && debug_mode;

	// halves only count in paired mode, so their prescalers are idle when joined
	assign hif_a.run = pair && timer_a_enable;
	assign hif_a.mode = half_a_mode;
	assign hif_a.load = q.load_a[15:0];
	assign hif_a.match = q.match_a[15:0];
	assign hif_a.prescale = q.pre_a;
	assign hif_a.load_strobe = q.ld_a;
	assign hif_a.stall = stall_a;
	assign hif_a.cap_edge = q.sync_a[1] && !q.sync_a[2];
	assign hif_b.run = pair && timer_b_enable;
	assign hif_b.mode = half_b_mode;
	assign hif_b.load = q.load_b;
	assign hif_b.match = q.match_b;
	assign hif_b.prescale = q.pre_b;
	assign hif_b.load_strobe = q.ld_b;
	assign hif_b.stall = debug_halt_option_b && debug_mode;
	assign hif_b.cap_edge = q.sync_b[1] && !q.sync_b[2];

	dtilm_half #(.CNT_W(DTILM_HALF_W), .PRE_W(DTILM_PRESCALE_W)) u_half_a (
		.clk(ref_clk),
		.rst_n(rst_n),
		.hif(hif_a.half)
	);
	dtilm_half #(.CNT_W(DTILM_HALF_W), .PRE_W(DTILM_PRESCALE_W)) u_half_b (
		.clk(ref_clk),
		.rst_n(rst_n),
		.hif(hif_b.half)
	);

	// seven event sources
	assign ev[DTILM_IRQ_A_TIMEOUT] = pair ? hif_a.timeout : q.t32_timeout;
	assign ev[DTILM_IRQ_A_CMATCH] = pair && hif_a.cap_match;
	assign ev[DTILM_IRQ_A_CEVENT] = pair && hif_a.cap_event;
	assign ev[DTILM_IRQ_RTC] = q.rtc_match;
	assign ev[DTILM_IRQ_B_TIMEOUT] = pair && hif_b.timeout;
	assign ev[DTILM_IRQ_B_CMATCH] = pair && hif_b.cap_match;
	assign ev[DTILM_IRQ_B_CEVENT] = pair && hif_b.cap_event;

	always_comb begin
		d = q;
		d.sync_a = {q.sync_a[1:0], ccp_a_in};
		d.sync_b = {q.sync_b[1:0], ccp_b_in};
		d.ld_a = 1'b0;
		d.ld_b = 1'b0;
		d.t32_timeout = 1'b0;
		d.rtc_match = 1'b0;
		d.rd_done = 1'b0;
		if (wr_valid) begin
			if (wr_target[DTILM_TGT_A]) begin
				case (wr_kind)
					DTILM_KIND_LOAD: begin
						d.load_a = wr_data;
						d.ld_a = 1'b1;
					end
					DTILM_KIND_MATCH: d.match_a = wr_data;
					DTILM_KIND_PRESCALE: d.pre_a = wr_data[7:0];
					default: ;
				endcase
			end
			if (wr_target[DTILM_TGT_B]) begin
				case (wr_kind)
					DTILM_KIND_LOAD: begin
						d.load_b = wr_data[15:0];
						d.ld_b = 1'b1;
					end
					DTILM_KIND_MATCH: d.match_b = wr_data[15:0];
					DTILM_KIND_PRESCALE: d.pre_b = wr_data[7:0];
					default: ;
				endcase
			end
		end
		// clear beats set on the same edge; leaving rtc mode also stops it
		if (join_mode == DTILM_J32_RTC) begin
			if (rtc_enable_clear) begin
				d.rtc_run = 1'b0;
			end else if (rtc_enable_set) begin
				d.rtc_run = 1'b1;
			end
		end else begin
			d.rtc_run = 1'b0;
		end
		// joined counter runs on every clock: no prescaler here
		if (!pair && timer_a_enable && !stall_a) begin
			case (join_mode)
				DTILM_J32_ONESHOT: begin
					if (q.cnt32 != 32'h0000_0000) begin
						d.cnt32 = q.cnt32 - 32'h0000_0001;
						d.t32_timeout = (q.cnt32 == 32'h0000_0001);
					end
				end
				DTILM_J32_PERIODIC: begin
					d.cnt32 = (q.cnt32 == 32'h0000_0000) ? q.load_a : q.cnt32 - 32'h0000_0001;
					d.t32_timeout = (q.cnt32 == 32'h0000_0001);
				end
				DTILM_J32_RTC: begin
					if (q.rtc_run) begin
						d.cnt32 = q.cnt32 + 32'h0000_0001;
						d.rtc_match = ((q.cnt32 + 32'h0000_0001) == q.match_a);
					end
				end
				default: ;
			endcase
		end
		if (wr_valid && wr_target[DTILM_TGT_A] && wr_kind == DTILM_KIND_LOAD) begin
			d.cnt32 = wr_data;
		end
		// new events win over a clear in the same cycle
		d.raw = (q.raw & ~(irq_clear_valid ? irq_clear_mask : 7'h00)) | ev;
		d.status = masked_status_select ? (d.raw & irq_enable) : d.raw;
		d.irq = |(d.raw & irq_enable);
		if (rd_valid) begin
			d.rd_done = 1'b1;
			// joined mode reads the full width through half a only
			case (rd_kind)
				DTILM_KIND_LOAD: d.rd_data = rd_half_b ? ext16(q.load_b) :
					(pair ? ext16(q.load_a[15:0]) : q.load_a);
				DTILM_KIND_MATCH: d.rd_data = rd_half_b ? ext16(q.match_b) :
					(pair ? ext16(q.match_a[15:0]) : q.match_a);
				DTILM_KIND_PRESCALE: d.rd_data = {24'h00_0000, rd_half_b ? q.pre_b : q.pre_a};
				DTILM_KIND_VALUE: d.rd_data = rd_half_b ? ext16(hif_b.count) :
					(pair ? ext16(hif_a.count) : q.cnt32);
				default: d.rd_data = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= TOP_RESET;
		end else begin
			q <= d;
		end
	end

	assign rd_data = q.rd_data;
	assign rd_done = q.rd_done;
	assign irq_status = q.status;
	assign irq_out = q.irq;
	assign ccp_a_out = hif_a.pwm;
	assign ccp_b_out = hif_b.pwm;
	// the capture pin turns into a driven output only in pwm mode
	assign ccp_a_oe = pair && (half_a_mode == DTILM_H_PWM);
	assign ccp_b_oe = pair && (half_b_mode == DTILM_H_PWM);

	default clocking dtilm_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	chk_clear_lands: assert property (irq_clear_valid
		|=> (q.raw & $past(irq_clear_mask) & ~$past(ev)) == 7'h00)
		else $error("cleared source still pending");
	chk_raw_sticky: assert property (!irq_clear_valid
		|=> (q.raw & $past(q.raw)) == $past(q.raw))
		else $error("raw flag dropped without clear");
	chk_irq_gate: assert property ($stable(irq_enable)
		|-> irq_out == |(q.raw & irq_enable))
		else $error("irq output not gated by enables");
	chk_status_view: assert property (##1 1'b1
		|-> irq_status == ($past(masked_status_select) ? (q.raw & $past(irq_enable)) : q.raw))
		else $error("status view wrong");
	chk_rtc_mode_only: assert property (join_mode != DTILM_J32_RTC
		|=> !q.rtc_run)
		else $error("rtc running outside rtc mode");
	chk_rtc_halt: assert property ((join_mode == DTILM_J32_RTC) && !q.rtc_run && !wr_valid
		|=> $stable(q.cnt32))
		else $error("rtc counted while halted");
	chk_join_no_prescale: assert property ((join_mode == DTILM_J32_ONESHOT) && timer_a_enable
		&& !stall_a && (q.cnt32 > 32'h0000_0001) && !wr_valid
		|=> q.cnt32 == $past(q.cnt32) - 32'h0000_0001)
		else $error("joined counter skipped a clock");
	chk_load_readback: assert property ((wr_valid && wr_target == 2'h1
		&& wr_kind == DTILM_KIND_LOAD && !pair)
		##1 (!wr_valid && !pair)
		##1 (rd_valid && !rd_half_b && rd_kind == DTILM_KIND_LOAD && !wr_valid && !pair)
		|=> rd_data == $past(wr_data, 3))
		else $error("load readback mismatch");
	cov_irq_rise: cover property ($rose(irq_out));
	cov_rtc_match: cover property (q.rtc_match);
	cov_clear_vs_event: cover property (irq_clear_valid && |(irq_clear_mask & ev));
endmodule : dtilm_timer

// >>> dtilm_tb.sv
/*
 self-checking bench for the dual timer top: value registers, live counts, rtc, capture, pwm,
 prescale, stall and interrupt status.
 assumes the design package is compiled first and the top keeps the hand-over port timing.
*/
module tb
	import dtilm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, reset_n, timer_a_enable, timer_b_enable, debug_halt_option_a;
	logic debug_halt_option_b, debug_mode, rtc_enable_set, rtc_enable_clear, wr_valid, rd_valid;
	logic rd_half_b, irq_clear_valid, masked_status_select, ccp_a_in, ccp_b_in, rd_done, irq_out;
	logic ccp_a_out, ccp_a_oe, ccp_b_out, ccp_b_oe;
	dtilm_join_type join_mode;
	dtilm_half_mode_type half_a_mode, half_b_mode;
	dtilm_kind_type wr_kind, rd_kind, k;
	logic [1:0] wr_target, t;
	logic [31:0] wr_data, rd_data, v1, v2;
	logic [6:0] irq_enable, irq_clear_mask, irq_status;
	int miscompares, check_count, seed, n;
	// behavioural model of the stored values and of the raw interrupt flags
	int m_ld[2], m_mt[2], m_ps[2], m_raw;
	logic [31:0] exp_q[$];

	dtilm_timer dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .join_mode(join_mode),
		.half_a_mode(half_a_mode), .half_b_mode(half_b_mode), .timer_a_enable(timer_a_enable),
		.timer_b_enable(timer_b_enable), .debug_halt_option_a(debug_halt_option_a),
		.debug_halt_option_b(debug_halt_option_b), .debug_mode(debug_mode),
		.rtc_enable_set(rtc_enable_set), .rtc_enable_clear(rtc_enable_clear),
		.wr_valid(wr_valid), .wr_target(wr_target), .wr_kind(wr_kind), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_half_b(rd_half_b), .rd_kind(rd_kind), .rd_data(rd_data),
		.rd_done(rd_done), .irq_enable(irq_enable), .irq_clear_valid(irq_clear_valid),
		.irq_clear_mask(irq_clear_mask), .masked_status_select(masked_status_select),
		.irq_status(irq_status), .irq_out(irq_out), .ccp_a_in(ccp_a_in), .ccp_a_out(ccp_a_out),
		.ccp_a_oe(ccp_a_oe), .ccp_b_in(ccp_b_in), .ccp_b_out(ccp_b_out), .ccp_b_oe(ccp_b_oe));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic conclude();
		if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude

	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : tick

	task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk_val

	task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] s);
		check_count++;
		if ($isunknown(s) || s < lo || s > hi) begin
			miscompares++;
			$display("BAD %s expected %h..%h seen %h", nm, lo, hi, s);
		end
	endtask : chk_rng

	task automatic wr(input logic [1:0] tg, input dtilm_kind_type kd, input logic [31:0] d);
		@(posedge ref_clk);
		wr_valid <= 1'b1;
		wr_target <= tg;
		wr_kind <= kd;
		wr_data <= d;
		@(posedge ref_clk);
		wr_valid <= 1'b0;
		for (int h = 0; h < 2; h++) begin
			if (tg[h]) begin
				case (kd)
					DTILM_KIND_LOAD: m_ld[h] = int'(d);
					DTILM_KIND_MATCH: m_mt[h] = int'(d);
					DTILM_KIND_PRESCALE: m_ps[h] = int'(d[7:0]);
					default: ;
				endcase
			end
		end
	endtask : wr

	task automatic rd(input bit hb, input dtilm_kind_type kd, output logic [31:0] v);
		int c;
		@(posedge ref_clk);
		rd_valid <= 1'b1;
		rd_half_b <= hb;
		rd_kind <= kd;
		@(posedge ref_clk);
		rd_valid <= 1'b0;
		#1;
		c = 0;
		while (rd_done !== 1'b1 && c < 8) begin
			@(posedge ref_clk);
			#1;
			c++;
		end
		chk_val("rd_done", 32'h1, {31'h0, rd_done});
		v = rd_data;
	endtask : rd

	function automatic logic [31:0] exp_reg(input int h, input dtilm_kind_type kd);
		logic [31:0] v;
		v = (kd == DTILM_KIND_LOAD) ? m_ld[h] : (kd == DTILM_KIND_MATCH) ? m_mt[h] : m_ps[h];
		// half b and every paired read are 16 bits wide
		if (h == 1 || join_mode == DTILM_PAIR16) v = v & 32'h0000_FFFF;
		return v;
	endfunction : exp_reg

	task automatic check_regs();
		logic [31:0] v;
		for (int h = 0; h < 2; h++) begin
			for (int kk = 0; kk < 3; kk++) begin
				exp_q.push_back(exp_reg(h, dtilm_kind_type'(kk)));
				rd(h[0], dtilm_kind_type'(kk), v);
				chk_val($sformatf("reg_h%0d_k%0d", h, kk), exp_q.pop_front(), v);
			end
		end
	endtask : check_regs

	task automatic stat();
		logic [6:0] r;
		tick(2);
		#1;
		r = 7'(m_raw);
		chk_val("irq_status", masked_status_select ? r & irq_enable : r, irq_status);
		chk_val("irq_out", |(r & irq_enable), irq_out);
	endtask : stat

	task automatic clr(input logic [6:0] m);
		@(posedge ref_clk);
		irq_clear_valid <= 1'b1;
		irq_clear_mask <= m;
		@(posedge ref_clk);
		irq_clear_valid <= 1'b0;
		m_raw = m_raw & ~int'(m);
	endtask : clr

	task automatic rtc_pulse(input bit set);
		@(posedge ref_clk);
		if (set) rtc_enable_set <= 1'b1;
		else rtc_enable_clear <= 1'b1;
		@(posedge ref_clk);
		rtc_enable_set <= 1'b0;
		rtc_enable_clear <= 1'b0;
	endtask : rtc_pulse

	// one rising edge on a capture pin, held long enough for the synchroniser
	task automatic ccp_edge(input bit b);
		@(posedge ref_clk);
		if (b) ccp_b_in <= 1'b1;
		else ccp_a_in <= 1'b1;
		tick(4);
		ccp_a_in <= 1'b0;
		ccp_b_in <= 1'b0;
		tick(4);
	endtask : ccp_edge

	initial begin
		#50us;
		miscompares++;
		conclude();
	end

	initial begin
		{reset_n, timer_a_enable, timer_b_enable, debug_halt_option_a, debug_halt_option_b} = '0;
		{debug_mode, rtc_enable_set, rtc_enable_clear, wr_valid, rd_valid, rd_half_b} = '0;
		{irq_clear_valid, masked_status_select, ccp_a_in, ccp_b_in} = '0;
		join_mode = DTILM_PAIR16;
		half_a_mode = DTILM_H_ONESHOT;
		half_b_mode = DTILM_H_ONESHOT;
		wr_kind = DTILM_KIND_LOAD;
		rd_kind = DTILM_KIND_LOAD;
		{wr_target, wr_data, irq_enable, irq_clear_mask} = '0;
		{miscompares, check_count, m_raw} = '0;
		m_ld = '{0, 0};
		m_mt = '{0, 0};
		m_ps = '{0, 0};
		seed = 34;
		tick(5);
		reset_n <= 1'b1;
		tick(3);
		check_regs();
		stat();
		wr(2'h3, DTILM_KIND_PRESCALE, 32'h0000_01FF);
		check_regs();
		repeat (8) begin
			t = 2'($random(seed));
			if (t == 2'h0) t = 2'h3;
			k = dtilm_kind_type'($random(seed));
			wr(t, k, $random(seed));
		end
		check_regs();
		wr(2'h3, DTILM_KIND_PRESCALE, 32'h0);
		// one-shot timeout, then enable, mask view and clear
		wr(2'h1, DTILM_KIND_LOAD, 32'h4);
		timer_a_enable <= 1'b1;
		tick(20);
		m_raw = 32'h1;
		stat();
		masked_status_select <= 1'b1;
		stat();
		irq_enable <= 7'h7F;
		stat();
		masked_status_select <= 1'b0;
		stat();
		clr(7'h7F);
		stat();
		timer_a_enable <= 1'b0;
		// reload while running lands at once
		half_a_mode <= DTILM_H_PERIODIC;
		wr(2'h1, DTILM_KIND_LOAD, 32'h0000_FFFF);
		timer_a_enable <= 1'b1;
		tick(10);
		wr(2'h1, DTILM_KIND_LOAD, 32'h64);
		rd(1'b0, DTILM_KIND_VALUE, v1);
		timer_a_enable <= 1'b0;
		chk_rng("live_a", 32'h5A, 32'h64, v1);
		// stall in debug, then run again with the option off
		wr(2'h1, DTILM_KIND_LOAD, 32'h0000_FFFF);
		debug_halt_option_a <= 1'b1;
		debug_mode <= 1'b1;
		timer_a_enable <= 1'b1;
		tick(10);
		rd(1'b0, DTILM_KIND_VALUE, v1);
		chk_val("stall_a", 32'h0000_FFFF, v1);
		debug_halt_option_a <= 1'b0;
		tick(10);
		rd(1'b0, DTILM_KIND_VALUE, v1);
		timer_a_enable <= 1'b0;
		debug_mode <= 1'b0;
		chk_rng("run_a", 32'h0000_FFD0, 32'h0000_FFFD, v1);
		// edge count reaches match on its second edge; edge time flags each edge
		half_b_mode <= DTILM_H_CAP_COUNT;
		wr(2'h2, DTILM_KIND_LOAD, 32'h5);
		wr(2'h2, DTILM_KIND_MATCH, 32'h3);
		timer_b_enable <= 1'b1;
		tick(3);
		ccp_edge(1'b1);
		ccp_edge(1'b1);
		// two edges flag the capture event, the second also the match
		m_raw = m_raw | 32'h60;
		stat();
		rd(1'b1, DTILM_KIND_VALUE, v1);
		chk_val("count_b", 32'h3, v1);
		half_a_mode <= DTILM_H_CAP_TIME;
		timer_a_enable <= 1'b1;
		ccp_edge(1'b0);
		m_raw = m_raw | 32'h4;
		stat();
		{timer_a_enable, timer_b_enable} <= 2'b00;
		clr(7'h7F);
		// pwm: period of load+1 ticks, high while count above match
		half_a_mode <= DTILM_H_PWM;
		wr(2'h1, DTILM_KIND_LOAD, 32'h9);
		wr(2'h1, DTILM_KIND_MATCH, 32'h3);
		timer_a_enable <= 1'b1;
		tick(25);
		n = 0;
		repeat (100) begin
			@(posedge ref_clk);
			#1;
			if (ccp_a_out === 1'b1) n++;
		end
		chk_val("pwm_high", 32'd60, n);
		chk_val("pwm_oe", 32'h1, {31'h0, ccp_a_oe});
		chk_val("pwm_b", 32'h0, {30'h0, ccp_b_oe, ccp_b_out});
		timer_a_enable <= 1'b0;
		tick(3);
		clr(7'h7F);
		stat();
		// rtc: enable ignored outside rtc mode, counts up, matches, halts
		join_mode <= DTILM_J32_ONESHOT;
		wr(2'h1, DTILM_KIND_LOAD, 32'h0);
		rtc_pulse(1'b1);
		join_mode <= DTILM_J32_RTC;
		timer_a_enable <= 1'b1;
		tick(10);
		rd(1'b0, DTILM_KIND_VALUE, v1);
		chk_val("rtc_idle", 32'h0, v1);
		wr(2'h1, DTILM_KIND_MATCH, 32'h28);
		rtc_pulse(1'b1);
		tick(60);
		m_raw = m_raw | 32'h8;
		stat();
		rtc_pulse(1'b0);
		rd(1'b0, DTILM_KIND_VALUE, v1);
		chk_rng("rtc_run", 32'h3C, 32'h60, v1);
		tick(10);
		rd(1'b0, DTILM_KIND_VALUE, v2);
		chk_val("rtc_halt", v1, v2);
		timer_a_enable <= 1'b0;
		clr(7'h7F);
		// prescale stretches a paired half and is ignored when joined
		join_mode <= DTILM_PAIR16;
		half_b_mode <= DTILM_H_ONESHOT;
		wr(2'h2, DTILM_KIND_PRESCALE, 32'hFF);
		wr(2'h2, DTILM_KIND_LOAD, 32'h2);
		timer_b_enable <= 1'b1;
		tick(100);
		stat();
		tick(900);
		m_raw = m_raw | 32'h10;
		stat();
		timer_b_enable <= 1'b0;
		join_mode <= DTILM_J32_ONESHOT;
		wr(2'h3, DTILM_KIND_PRESCALE, 32'hFF);
		wr(2'h1, DTILM_KIND_LOAD, 32'hA);
		timer_a_enable <= 1'b1;
		tick(30);
		m_raw = m_raw | 32'h1;
		stat();
		// joined periodic reloads at zero, so a later read stays inside the period
		clr(7'h7F);
		join_mode <= DTILM_J32_PERIODIC;
		wr(2'h1, DTILM_KIND_LOAD, 32'h5);
		tick(20);
		rd(1'b0, DTILM_KIND_VALUE, v1);
		chk_rng("per32", 32'h1, 32'h3, v1);
		m_raw = m_raw | 32'h1;
		stat();
		wr(2'h1, DTILM_KIND_LOAD, $random(seed));
		check_regs();
		conclude();
	end
endmodule : tb
